// >>> verilog/pioc_pkg.sv
package pioc_pkg;
  // Fixed block dimensions
  localparam int NUM_PINS = 8;
  localparam int NUM_GOE = 6;
  localparam int GOE_SEL_W = 3;
  localparam int LP_DELAY_CYC = 2;
  localparam int REG_NUM = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OESEL_LO = 8'h04;
  localparam logic [7:0] OFS_OESEL_HI = 8'h08;
  localparam logic [7:0] OFS_GOESRC = 8'h0C;
  localparam logic [7:0] OFS_GOEIDX = 8'h10;
  localparam logic [7:0] OFS_SPEED = 8'h14;
  localparam logic [7:0] OFS_PINS = 8'h18;
  localparam logic [7:0] OFS_MCOUT = 8'h1C;
  // Enable select codes per pin
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_GOE0 = 3'h2;
  // Global enable source codes, larger variant
  localparam logic [1:0] SRC_PIN_A = 2'h0;
  localparam logic [1:0] SRC_PIN_B = 2'h1;
  localparam logic [1:0] SRC_IO_PIN = 2'h2;
  localparam logic [1:0] SRC_MACRO = 2'h3;
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_SPEED = 32'h0000_00FF;
  typedef enum {ST_RUN, ST_PROG, ST_RESTORE} pioc_state_type;
endpackage : pioc_pkg

// >>> verilog/pioc_pin_cell.sv
`timescale 1ns/10ps
// One pin: enable selection, programming override, feedbacks
module pioc_pin_cell (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] sel,
  input wire logic [5:0] goe,
  input wire logic prog,
  input wire logic fast,
  input wire logic mc_data,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_pull,
  output logic pin_fb,
  output logic mc_fb
);
  logic [pioc_pkg::LP_DELAY_CYC-1:0] dly_reg;
  logic en_sel;
  logic mc_path;
  // Enable from constant or one of the global enables
  assign en_sel = (sel == pioc_pkg::SEL_LOW) ? 1'b0 :
    (sel == pioc_pkg::SEL_HIGH) ? 1'b1 :
    goe[sel - pioc_pkg::SEL_GOE0]; // [R02] [R05]
  // Low power path adds fixed latency of extra stages
  assign mc_path = fast ? mc_data :
    dly_reg[pioc_pkg::LP_DELAY_CYC - 1]; // [R09]
  // Outputs registered; programming forces high-Z and pull-up
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dly_reg <= '0;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pin_pull <= 1'b0;
      pin_fb <= 1'b0;
      mc_fb <= 1'b0;
    end else begin
      dly_reg <= {dly_reg[pioc_pkg::LP_DELAY_CYC - 2:0], mc_data};
      pin_out <= mc_path;
      pin_oe_n <= prog | ~en_sel; // [R07] [R10] [R01]
      pin_pull <= prog; // [R07]
      pin_fb <= pin_in; // [R06]
      mc_fb <= mc_path; // [R06]
    end
  end
endmodule : pioc_pin_cell

// >>> verilog/pioc_io_ctrl.sv
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
// Function
// R01: Each pin configurable as input, output or bidirectional.
// R02: Pin enable chosen from global enables, constant low or high.
// R03: Small variant: two global enables from active-low pins.
// R04: Large variant: six enables from enable pins, I/O pins, macrocells.
// R05: Select low means high-Z input; select high means always driving.
// R06: Separate pin and macrocell feedback; buried logic stays usable.
// R07: During programming all pins high-Z with pull-up.
// R08: Programming via four-signal test access port, driven by programmer; code uses one in_circuit_programming input or control bit 0 instead.
// R09: Per macrocell speed/power bit; low power adds fixed delay.
// R10: After programming, pins return to stored configuration.
module pioc_io_ctrl #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic global_enable_pin_a_n,
  input wire logic global_enable_pin_b_n,
  input wire logic in_circuit_programming,
  input wire logic [7:0] mc_data,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_pull,
  output logic [7:0] pin_fb,
  output logic [7:0] mc_fb,
  output logic prog_active
);
  logic [31:0] ctrl_reg;
  logic [31:0] oesel_lo_reg;
  logic [31:0] oesel_hi_reg;
  logic [31:0] goesrc_reg;
  logic [31:0] goeidx_reg;
  logic [31:0] speed_reg;
  pioc_pkg::pioc_state_type state_reg;
  pioc_pkg::pioc_state_type state_next;
  logic [5:0] goe;
  logic [23:0] sel_all;
  logic [31:0] rd_mux;
  logic hit;
  logic req;
  logic prog_req;
  logic prog_gate;
  logic [4:0] word_ofs;

  // All checks below run on the core clock, quiet during reset
  default clocking cb_core @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Address decode; unmapped answers with err
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit = ({wb_adr_i[5:2], 2'b00} <= pioc_pkg::OFS_MCOUT[5:0]);
  assign word_ofs = {wb_adr_i[4:2], 2'b00};
  assign rd_mux =
    (word_ofs == pioc_pkg::OFS_CTRL[4:0]) ? {31'h0, ctrl_reg[0]} :
    (word_ofs == pioc_pkg::OFS_OESEL_LO[4:0]) ? oesel_lo_reg :
    (word_ofs == pioc_pkg::OFS_OESEL_HI[4:0]) ? oesel_hi_reg :
    (word_ofs == pioc_pkg::OFS_GOESRC[4:0]) ? goesrc_reg :
    (word_ofs == pioc_pkg::OFS_GOEIDX[4:0]) ? goeidx_reg :
    (word_ofs == pioc_pkg::OFS_SPEED[4:0]) ? {24'h0, speed_reg[7:0]} :
    (word_ofs == pioc_pkg::OFS_PINS[4:0]) ? {16'h0, pin_fb, ~pin_oe_n} :
    {30'h0, prog_active, state_reg == pioc_pkg::ST_RESTORE};

  // Programming request: port or software bit
  assign prog_req = in_circuit_programming | ctrl_reg[0]; // [R08]

  // Programming state: override until request drops, then one restore cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pioc_pkg::ST_RUN: if (prog_req) state_next = pioc_pkg::ST_PROG;
      pioc_pkg::ST_PROG: if (!prog_req) state_next = pioc_pkg::ST_RESTORE;
      default: state_next = prog_req ? pioc_pkg::ST_PROG : pioc_pkg::ST_RUN;
    endcase
  end
  assign prog_gate = (state_reg == pioc_pkg::ST_PROG) |
    prog_req; // [R07] [R10]

  // Global enable generation per variant
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_goe
      if (LARGE_VARIANT) begin : gl
        logic src;
        assign src =
          (goesrc_reg[g*4 +: 2] == pioc_pkg::SRC_PIN_A) ?
            ~global_enable_pin_a_n :
          (goesrc_reg[g*4 +: 2] == pioc_pkg::SRC_PIN_B) ?
            ~global_enable_pin_b_n :
          (goesrc_reg[g*4 +: 2] == pioc_pkg::SRC_IO_PIN) ?
            pin_in[goeidx_reg[g*4 +: 3]] :
            mc_data[goeidx_reg[g*4 +: 3]]; // [R04]
        assign goe[g] = src ^ goesrc_reg[g*4 + 2]; // [R04]
      end else begin : gs
        if (g == 0) begin : a
          assign goe[g] = ~global_enable_pin_a_n; // [R03]
        end else if (g == 1) begin : b
          assign goe[g] = ~global_enable_pin_b_n; // [R03]
        end else begin : z
          assign goe[g] = 1'b0;
        end
      end
    end
  endgenerate

  assign sel_all = {oesel_hi_reg[11:0], oesel_lo_reg[11:0]};

  // Per-pin cells
  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : gen_pin
      pioc_pin_cell u_cell (
        .clk(clk),
        .resetn(resetn),
        .sel(sel_all[p*3 +: 3]), // [R01] [R02]
        .goe(goe),
        .prog(prog_gate),
        .fast(speed_reg[p]), // [R09]
        .mc_data(mc_data[p]),
        .pin_in(pin_in[p]),
        .pin_out(pin_out[p]),
        .pin_oe_n(pin_oe_n[p]),
        .pin_pull(pin_pull[p]),
        .pin_fb(pin_fb[p]), // [R06]
        .mc_fb(mc_fb[p]) // [R06]
      );
    end
  endgenerate

  // Register writes, state and bus answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= pioc_pkg::RST_CTRL;
      oesel_lo_reg <= pioc_pkg::RST_ZERO;
      oesel_hi_reg <= pioc_pkg::RST_ZERO;
      goesrc_reg <= pioc_pkg::RST_ZERO;
      goeidx_reg <= pioc_pkg::RST_ZERO;
      speed_reg <= pioc_pkg::RST_SPEED;
      state_reg <= pioc_pkg::ST_RUN;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      prog_active <= 1'b0;
    end else begin
      state_reg <= state_next;
      prog_active <= prog_req; // [R07]
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req & hit & ~wb_we_i) wb_dat_o <= rd_mux;
      if (req & hit & wb_we_i) begin
        if (word_ofs == pioc_pkg::OFS_CTRL[4:0])
          ctrl_reg <= lane_merge(ctrl_reg, wb_dat_i, wb_sel_i);
        else if (word_ofs == pioc_pkg::OFS_OESEL_LO[4:0])
          oesel_lo_reg <= lane_merge(oesel_lo_reg, wb_dat_i, wb_sel_i);
        else if (word_ofs == pioc_pkg::OFS_OESEL_HI[4:0])
          oesel_hi_reg <= lane_merge(oesel_hi_reg, wb_dat_i, wb_sel_i);
        else if (word_ofs == pioc_pkg::OFS_GOESRC[4:0])
          goesrc_reg <= lane_merge(goesrc_reg, wb_dat_i, wb_sel_i);
        else if (word_ofs == pioc_pkg::OFS_GOEIDX[4:0])
          goeidx_reg <= lane_merge(goeidx_reg, wb_dat_i, wb_sel_i);
        else if (word_ofs == pioc_pkg::OFS_SPEED[4:0])
          speed_reg <= lane_merge(speed_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Checks
  a_prog_hiz: assert property ( // [R07]
    prog_req |=> (&pin_oe_n) && (&pin_pull))
    else $error("pins not released during programming");
  // Pull-ups all off one edge after the restore cycle
  a_prog_restore: assert property ( // [R10]
    $fell(prog_req) ##1 !prog_req |=> !(|pin_pull))
    else $error("pull-up stuck after programming");
  // First edge out of reset still shows the reset value
  a_fb_follow: assert property ( // [R06]
    $past(resetn) |-> pin_fb == $past(pin_in))
    else $error("pin feedback wrong");
  a_low_hiz: assert property ( // [R05]
    (sel_all[2:0] == pioc_pkg::SEL_LOW) |=> pin_oe_n[0])
    else $error("select low not high-Z");
  a_high_drive: assert property ( // [R05] [R01]
    (sel_all[2:0] == pioc_pkg::SEL_HIGH) && !prog_gate |=> !pin_oe_n[0])
    else $error("select high not driving");
  // Pin 2 is the one the bench puts on global enable 0
  a_goe_sel: assert property ( // [R02]
    (sel_all[8:6] == pioc_pkg::SEL_GOE0) && !prog_gate
    |=> pin_oe_n[2] == !$past(goe[0]))
    else $error("global enable not followed");
  a_small_goe: assert property ( // [R03]
    !LARGE_VARIANT |-> goe == {4'h0, ~global_enable_pin_b_n,
    ~global_enable_pin_a_n})
    else $error("small variant enable wrong");
  a_large_goe: assert property ( // [R04]
    LARGE_VARIANT && goesrc_reg[3:0] == 4'h4 |->
    goe[0] == global_enable_pin_a_n)
    else $error("inverted enable wrong");
  a_lowpow_dly: assert property ( // [R09]
    !speed_reg[0] ##1 !speed_reg[0] ##1 !speed_reg[0]
    |=> mc_fb[0] == $past(mc_data[0], 3))
    else $error("low power delay wrong");
  a_prog_port: assert property ( // [R08]
    in_circuit_programming |=> prog_active)
    else $error("programming not seen");
  c_prog: cover property ($fell(prog_active));
  c_bidir: cover property ($rose(pin_oe_n[0]));
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule : pioc_io_ctrl

// >>> tb/pioc_board_model.sv
`timescale 1ns/10ps
// Board side of the pins: other drivers, pull-ups, floating lines
module pioc_board_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_pull,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] float_reg = 8'h00;
  // Undriven lines toggle so a stale level never passes
  always @(posedge clk) float_reg <= ~float_reg;
  // Device first, then board driver, then weak pull-up
  assign pin_in = (~pin_oe_n & pin_out)
    | (pin_oe_n & ext_en & ext_drv)
    | (pin_oe_n & ~ext_en & pin_pull)
    | (pin_oe_n & ~ext_en & ~pin_pull & float_reg);
endmodule : pioc_board_model

// >>> tb/pioc_io_ctrl_tb_top.sv
`timescale 1ns/10ps
// Pin enable controller, driven over the register bus
module pioc_io_ctrl_tb_top;
  logic clk, resetn, we, cyc, stb, ena_n, enb_n, icp, ack, err, pact, e;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [3:0] sel;
  logic [7:0] mc, pin_in, pout, oen, pull, pfb, mcfb, xdrv, xen;
  logic [7:0] s_oen;
  int failures, total_checks, cyc_cnt;
  pioc_io_ctrl #(.LARGE_VARIANT(1'h1)) i_pioc_io_ctrl (.clk(clk),
    .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .wb_err_o(err), .global_enable_pin_a_n(ena_n),
    .global_enable_pin_b_n(enb_n), .in_circuit_programming(icp),
    .mc_data(mc), .pin_in(pin_in), .pin_out(pout), .pin_oe_n(oen),
    .pin_pull(pull), .pin_fb(pfb), .mc_fb(mcfb), .prog_active(pact));
  pioc_board_model i_pioc_board_model (.clk(clk), .pin_out(pout),
    .pin_oe_n(oen), .pin_pull(pull), .ext_drv(xdrv), .ext_en(xen),
    .pin_in(pin_in));
  // Two-enable variant on the same bus and pins; only enables watched
  pioc_io_ctrl #(.LARGE_VARIANT(1'h0)) i_pioc_io_ctrl_small (.clk(clk),
    .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(), .wb_err_o(), .global_enable_pin_a_n(ena_n),
    .global_enable_pin_b_n(enb_n), .in_circuit_programming(icp),
    .mc_data(mc), .pin_in(pin_in), .pin_out(), .pin_oe_n(s_oen),
    .pin_pull(), .pin_fb(), .mc_fb(), .prog_active());
  // Clock at 25 ns
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Classic single cycle; held until ack or err is sampled
  task wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'h1;
    stb <= 1'h1;
    do @(posedge clk); while (ack !== 1'h1 && err !== 1'h1);
    r = rdat;
    e = err;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  task cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task t_reset;
    chk("oe_n", 32'hFF, oen);
    wb(6'h14, 1'h0, 32'h0);
    chk("speed", 32'hFF, r);
    wb(6'h20, 1'h0, 32'h0);
    chk("err", 32'h1, e);
  endtask : t_reset
  // Pin0 driven, pin1 input, pin2 on global enable 0
  task t_dir;
    wb(6'h04, 1'h1, 32'h81);
    cy(2);
    chk("oe_n", 32'hFE, oen);
    chk("out0", 32'h1, pout[0]);
  endtask : t_dir
  // Each enable source: pin a, inverted, pin b, io pin, macrocell
  task t_goe;
    logic [3:0] src [5];
    logic [7:0] exp [5];
    src = '{4'h0, 4'h4, 4'h1, 4'h2, 4'h3};
    exp = '{8'hFA, 8'hFE, 8'hFE, 8'hFA, 8'hFA};
    wb(6'h10, 1'h1, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wb(6'h0C, 1'h1, {28'h0, src[i]});
      cy(3);
      chk("goe_oe_n", {24'h0, exp[i]}, oen);
    end
  endtask : t_goe
  // Two-enable variant: pin 2 follows enable pin a
  task t_small;
    chk("small_oe_n", 32'hFA, s_oen);
    @(posedge clk);
    ena_n <= 1'h1;
    cy(2);
    chk("small_oe_n", 32'hFE, s_oen);
    @(posedge clk);
    ena_n <= 1'h0;
    cy(1);
  endtask : t_small
  // Input pin 1 follows the board; its macrocell stays usable
  task t_fb;
    chk("pin_fb1", 32'h1, pfb[1]);
    @(posedge clk);
    xdrv <= 8'h00;
    cy(2);
    chk("pin_fb1", 32'h0, pfb[1]);
    chk("mc_fb1", 32'h1, mcfb[1]);
  endtask : t_fb
  // Programming by port, then by control bit
  task t_prog;
    @(posedge clk);
    icp <= 1'h1;
    cy(2);
    chk("oe_n", 32'hFF, oen);
    chk("pull", 32'hFF, pull);
    chk("prog", 32'h1, pact);
    wb(6'h1C, 1'h0, 32'h0);
    chk("status", 32'h2, r);
    @(posedge clk);
    icp <= 1'h0;
    cy(4);
    chk("oe_n", 32'hFA, oen);
    chk("pull", 32'h0, pull);
    wb(6'h00, 1'h1, 32'h1);
    cy(2);
    chk("oe_n", 32'hFF, oen);
    wb(6'h00, 1'h0, 32'h0);
    chk("ctrl", 32'h1, r);
    wb(6'h00, 1'h1, 32'h0);
    cy(4);
    chk("oe_n", 32'hFA, oen);
  endtask : t_prog
  // Low-power macrocell 0: two extra cycles
  task t_speed;
    wb(6'h14, 1'h1, 32'hFE);
    @(posedge clk);
    mc <= 8'h02;
    cy(2);
    chk("slow_out0", 32'h1, pout[0]);
    cy(1);
    chk("slow_out0", 32'h0, pout[0]);
  endtask : t_speed
  // Main sequence
  initial begin
    {we, cyc, stb, icp, e} = 5'h0;
    {ena_n, enb_n} = 2'h3;
    adr = 6'h0;
    wdat = 32'h0;
    sel = 4'hF;
    mc = 8'h03;
    xdrv = 8'h00;
    xen = 8'h02;
    resetn = 1'h0;
    // Three edges see reset low; release lands on the third
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    cy(1);
    t_reset();
    t_dir();
    @(posedge clk);
    ena_n <= 1'h0;
    xdrv <= 8'h02;
    t_goe();
    t_small();
    t_fb();
    t_prog();
    t_speed();
    end_of_test();
  end
endmodule : pioc_io_ctrl_tb_top
